//--- rtl/supply_supervisory_controller.sv
// supervisory monitors, default saving, recorder, trip and process loop
`timescale 1ns/1ps
module supply_supervisory_controller
   import supv_pkg::*;
#(
   parameter int unsigned DIV = LOOP_DIV
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // register writes from host link
   input wire logic wr_en_i,
   input wire wregs_t wr_data_i,
   input wire logic cmd_wr_i,
   input wire logic [15:0] cmd_code_i,
   input wire logic link_activity_i,
   // command bits
   input wire logic imp_mon_en_i,
   input wire logic link_tmo_en_i,
   input wire logic recorder_enable_i,
   input wire logic fault_reset_i,
   input wire logic digital_prog_i,
   input wire logic process_mode_i,
   input wire logic proc_sp_analog_i,
   input wire logic proc_drive_current_i,
   input wire logic proc_analog_cap_i,
   // measurements, normalized q15
   input wire logic [31:0] v_meas_i,
   input wire logic [31:0] i_meas_i,
   input wire logic [31:0] z_rate_i,
   input wire logic [31:0] ext_faults_i,
   input wire logic warning_i,
   input wire logic [31:0] v_prog_i,
   input wire logic [31:0] i_prog_i,
   input wire logic [31:0] p_prog_i,
   input wire logic [31:0] v_setpoint_i,
   input wire logic [31:0] i_setpoint_i,
   input wire logic [31:0] p_setpoint_i,
   input wire logic [23:0] rtc_i,
   input wire logic [7:0] module_count_i,
   // outputs
   output logic [15:0] cmd_readback_o,
   output wregs_t regs_o,
   output logic [31:0] fault_bits_o,
   output logic shutdown_o,
   output logic fault_reset_clr_o,
   output logic ready_o,
   output logic record_o,
   output rec_entry_t record_entry_o,
   output logic save_request_o,
   output logic [31:0] v_cmd_o,
   output logic [31:0] i_cmd_o
);
   typedef struct packed {
      nv_st_t st;
      wregs_t regs;
      logic [3:0] idx;
      logic rd_wait;
      logic [15:0] cmd_rb;
      logic [31:0] faults;
      logic shut;
      logic rst_prev;
      logic rst_clr;
      logic [31:0] tmo_cnt;
      logic [31:0] div_cnt;
      logic tick;
      logic [31:0] rec_cnt;
      logic rec;
      logic save_req;
      logic warn_prev;
      logic [31:0] flt_prev;
      rec_entry_t entry;
      logic signed [31:0] e1;
      logic signed [31:0] e2;
      logic signed [31:0] u1;
      logic signed [31:0] u2;
      logic [31:0] v_cmd;
      logic [31:0] i_cmd;
   } state_t;

   state_t cur_ff;
   state_t nxt_ff;
   logic [31:0] nv_rdata;
   logic nv_we;
   logic [31:0] nv_wdata;

   nv_image_mem #(.DEPTH(NV_WORDS)) u_nv (
      .clk_i(clk_i),
      .wr_en_i(nv_we),
      .addr_i(cur_ff.idx),
      .wdata_i(nv_wdata),
      .rdata_o(nv_rdata)
   );

   function automatic logic [31:0] get_word(input wregs_t w,
                                            input logic [3:0] i);
      logic [NV_WORDS*32-1:0] flat;
      flat = w;
      return flat[(NV_WORDS-1-i)*32 +: 32];
   endfunction

   function automatic wregs_t put_word(input wregs_t w, input logic [3:0] i,
                                       input logic [31:0] d);
      logic [NV_WORDS*32-1:0] flat;
      flat = w;
      flat[(NV_WORDS-1-i)*32 +: 32] = d;
      return flat;
   endfunction

   function automatic logic signed [63:0] mul_q(input logic signed [31:0] a,
                                                input logic signed [31:0] b);
      logic signed [63:0] p;
      p = a * b;
      return p >>> FRAC;
   endfunction

   assign nv_we = (cur_ff.st == ST_STORE);
   assign nv_wdata = get_word(cur_ff.regs, cur_ff.idx);

   always_comb begin
      logic [63:0] zv;
      logic [63:0] zlo;
      logic [63:0] zhi;
      logic signed [31:0] sp;
      logic signed [31:0] fb;
      logic signed [31:0] err;
      logic signed [63:0] acc;
      logic signed [31:0] u;
      logic [31:0] cap;
      logic [31:0] trig;
      logic new_flt;
      zv = '0;
      zlo = '0;
      zhi = '0;
      sp = '0;
      fb = '0;
      err = '0;
      acc = '0;
      u = '0;
      cap = '0;
      trig = '0;
      new_flt = 1'b0;
      nxt_ff = cur_ff;
      nxt_ff.rst_clr = 1'b0;
      nxt_ff.rec = 1'b0;
      nxt_ff.save_req = 1'b0;
      nxt_ff.tick = 1'b0;

      // store writes a word a cycle, load takes two
      case (cur_ff.st)
         ST_BOOT: begin
            nxt_ff.st = ST_LOAD; // R4
            nxt_ff.idx = '0;
            nxt_ff.rd_wait = 1'b1;
            nxt_ff.cmd_rb = CMD_BUSY;
         end
         ST_IDLE: begin
            if (wr_en_i) begin
               nxt_ff.regs = wr_data_i;
            end
            if (cmd_wr_i) begin
               nxt_ff.cmd_rb = CMD_BUSY; // R26
               nxt_ff.idx = '0;
               nxt_ff.rd_wait = 1'b1;
               case (cmd_code_i)
                  CMD_STORE: nxt_ff.st = ST_STORE; // R3
                  CMD_RESTORE: nxt_ff.st = ST_LOAD; // R5
                  CMD_FACTORY: begin
                     nxt_ff.regs = factory_image(); // R6
                     nxt_ff.cmd_rb = CMD_DONE; // R7
                  end
                  default: nxt_ff.cmd_rb = cmd_code_i;
               endcase
            end
         end
         ST_LOAD: begin
            // read data lag the address a cycle
            if (cur_ff.rd_wait) begin
               nxt_ff.rd_wait = 1'b0;
            end else begin
               nxt_ff.regs = put_word(cur_ff.regs, cur_ff.idx, nv_rdata);
               nxt_ff.rd_wait = 1'b1;
               if (cur_ff.idx == 4'(NV_WORDS - 1)) begin
                  nxt_ff.st = ST_IDLE;
                  nxt_ff.cmd_rb = CMD_DONE; // R7
               end else begin
                  nxt_ff.idx = cur_ff.idx + 4'h1;
               end
            end
         end
         ST_STORE: begin
            if (cur_ff.idx == 4'(NV_WORDS - 1)) begin
               nxt_ff.st = ST_IDLE;
               nxt_ff.cmd_rb = CMD_DONE; // R7
            end else begin
               nxt_ff.idx = cur_ff.idx + 4'h1;
            end
         end
         default: nxt_ff.st = ST_BOOT;
      endcase

      // impedance window, v/i by cross multiplication
      zv = {32'h0, v_meas_i} << 24;
      zlo = 64'(i_meas_i) * 64'(cur_ff.regs.z_min);
      zhi = 64'(i_meas_i) * 64'(cur_ff.regs.z_max);
      if (imp_mon_en_i && (zv > zhi || zv < zlo)) begin
         trig[FLT_IMP] = 1'b1; // R1
      end
      if (imp_mon_en_i &&
          ($signed(z_rate_i) > $signed(cur_ff.regs.rate_max) ||
           $signed(z_rate_i) < $signed(cur_ff.regs.rate_min))) begin
         trig[FLT_ROC] = 1'b1; // R2
      end

      // link inactivity counter; zero period disables it
      if (link_activity_i || !link_tmo_en_i) begin
         nxt_ff.tmo_cnt = '0;
      end else if (cur_ff.tmo_cnt != cur_ff.regs.timeout_period) begin // R9
         nxt_ff.tmo_cnt = cur_ff.tmo_cnt + 32'h1;
      end
      if (link_tmo_en_i && cur_ff.regs.timeout_period != '0 &&
          cur_ff.tmo_cnt == cur_ff.regs.timeout_period) begin
         trig[FLT_LINK] = 1'b1; // R8
      end
      trig = trig | ext_faults_i;

      // sticky faults; new fault outranks the reset edge
      nxt_ff.rst_prev = fault_reset_i;
      if (fault_reset_i && !cur_ff.rst_prev) begin
         nxt_ff.faults = trig; // R24
         nxt_ff.shut = |(trig & (cur_ff.regs.trip_mask | HARD_MASK));
         nxt_ff.rst_clr = 1'b1; // R24
      end else begin
         nxt_ff.faults = cur_ff.faults | trig;
         if (|(nxt_ff.faults & (cur_ff.regs.trip_mask | HARD_MASK))) begin
            nxt_ff.shut = 1'b1; // R16 R17
         end
      end

      // loop sample divider
      if (cur_ff.div_cnt == DIV - 1) begin
         nxt_ff.div_cnt = '0;
         nxt_ff.tick = 1'b1; // R20
      end else begin
         nxt_ff.div_cnt = cur_ff.div_cnt + 32'h1;
      end

      // recorder: interval counted in loop ticks
      nxt_ff.warn_prev = warning_i;
      nxt_ff.flt_prev = cur_ff.faults;
      new_flt = (warning_i && !cur_ff.warn_prev) ||
                |(cur_ff.faults & ~cur_ff.flt_prev);
      if (cur_ff.tick && cur_ff.regs.recorder_interval != '0) begin
         if (cur_ff.rec_cnt >= cur_ff.regs.recorder_interval - 32'h1) begin
            nxt_ff.rec_cnt = '0;
            nxt_ff.rec = 1'b1; // R10
            nxt_ff.save_req = recorder_enable_i; // R12
         end else begin
            nxt_ff.rec_cnt = cur_ff.rec_cnt + 32'h1;
         end
      end
      if (new_flt) begin
         nxt_ff.rec = 1'b1; // R10
      end
      if (nxt_ff.rec) begin
         nxt_ff.entry.header = REC_HEADER; // R14
         nxt_ff.entry.stamp = rtc_i; // R11
         nxt_ff.entry.command_word = {7'h0, proc_analog_cap_i,
            proc_drive_current_i, proc_sp_analog_i, process_mode_i,
            digital_prog_i, recorder_enable_i, link_tmo_en_i,
            imp_mon_en_i, fault_reset_i};
         nxt_ff.entry.status = {7'h0, cur_ff.shut};
         nxt_ff.entry.module_count = module_count_i;
         nxt_ff.entry.words = {cur_ff.faults, {31'h0, warning_i},
            cur_ff.faults & ~(cur_ff.regs.trip_mask | HARD_MASK),
            v_setpoint_i, i_setpoint_i, v_meas_i, i_meas_i, 32'h0,
            z_rate_i, 32'h0, {24'h0, module_count_i}, 32'h0, 32'h0,
            cur_ff.faults & (cur_ff.regs.trip_mask | HARD_MASK)}; // R14
      end

      // process loop
      fb = $signed(p_prog_i); // R18
      sp = proc_sp_analog_i ? $signed(v_prog_i)
                            : $signed(p_setpoint_i); // R19
      sp = sat_q(64'(sp)); // R18
      fb = sat_q(64'(fb)); // R18
      err = sp - fb;
      acc = mul_q($signed(cur_ff.regs.coef[0]), err) +
            mul_q($signed(cur_ff.regs.coef[1]), cur_ff.e1) +
            mul_q($signed(cur_ff.regs.coef[2]), cur_ff.e2) +
            mul_q($signed(cur_ff.regs.coef[3]), cur_ff.u1) +
            mul_q($signed(cur_ff.regs.coef[4]), cur_ff.u2); // R20
      u = sat_q(acc);
      if (!digital_prog_i) begin // R25
         cap = proc_drive_current_i ? i_prog_i : v_prog_i;
         if (proc_analog_cap_i) begin
            cap = i_prog_i; // R23
         end
      end else begin
         cap = proc_drive_current_i ? i_setpoint_i : v_setpoint_i; // R23
      end
      if (u > $signed(cap) && (digital_prog_i || proc_analog_cap_i)) begin
         u = $signed(cap); // R23
      end
      if (process_mode_i) begin
         if (cur_ff.tick) begin
            nxt_ff.e2 = cur_ff.e1;
            nxt_ff.e1 = err;
            nxt_ff.u2 = cur_ff.u1;
            nxt_ff.u1 = u;
            if (proc_drive_current_i) begin // R22
               nxt_ff.i_cmd = u;
               nxt_ff.v_cmd = v_setpoint_i;
            end else begin
               nxt_ff.v_cmd = u;
               nxt_ff.i_cmd = i_setpoint_i;
            end
         end
      end else begin
         nxt_ff.e1 = '0;
         nxt_ff.e2 = '0;
         nxt_ff.u1 = '0;
         nxt_ff.u2 = '0;
         nxt_ff.v_cmd = digital_prog_i ? v_setpoint_i : v_prog_i; // R25
         nxt_ff.i_cmd = digital_prog_i ? i_setpoint_i : i_prog_i; // R25
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cur_ff <= '0;
         cur_ff.st <= ST_BOOT;
         cur_ff.regs <= factory_image();
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign cmd_readback_o = cur_ff.cmd_rb;
   assign regs_o = cur_ff.regs;
   assign fault_bits_o = cur_ff.faults;
   assign shutdown_o = cur_ff.shut;
   assign fault_reset_clr_o = cur_ff.rst_clr;
   assign ready_o = (cur_ff.st == ST_IDLE);
   assign record_o = cur_ff.rec;
   assign record_entry_o = cur_ff.entry;
   assign save_request_o = cur_ff.save_req;
   assign v_cmd_o = cur_ff.v_cmd;
   assign i_cmd_o = cur_ff.i_cmd;
endmodule

//--- rtl/supv_pkg.sv
// constants and carrier types of the supervisory controller
// Notes on behaviour
// R1: impedance outside max/min window raises fault
// R2: impedance change rate outside window raises fault
// R3: code 0x1234 stores writable registers as defaults
// R4: power-on loads saved defaults before operation
// R5: code 0x5678 reloads saved defaults
// R6: code 0x9ABC reloads factory values
// R7: completed command reads back 0x1111
// R8: link silence past interval raises fault
// R9: interval comes from timeout period register
// R10: record at interval and on warning/fault
// R11: each entry stamped with 24-bit time
// R12: recorder enable broadcasts periodic save request
// R13: modules stamp faults with time plus increment
// R14: master entry layout header time command words
// R15: module entry layout is module's own
// R16: 32-bit trip mask selects shutdown faults
// R17: hard faults always shut down
// R18: process feedback from power input, 0..1.0
// R19: setpoint from power register or voltage input
// R20: two-pole two-zero compensator at 125Hz
// R21: host loads five coefficients at 51..60
// R22: loop output drives voltage or current command
// R23: loop output capped by input or setpoints
// R24: fault reset edge clears history, self-clears
// R25: digital bit selects register setpoints
// R26: pending command reads non-completion code
package supv_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned LOOP_HZ = 125;
   localparam int unsigned LOOP_DIV = CLK_HZ / LOOP_HZ;
   localparam logic [15:0] CMD_STORE = 16'h1234;
   localparam logic [15:0] CMD_RESTORE = 16'h5678;
   localparam logic [15:0] CMD_FACTORY = 16'h9abc;
   localparam logic [15:0] CMD_DONE = 16'h1111;
   localparam logic [15:0] CMD_BUSY = 16'h0000;
   localparam logic [15:0] REC_HEADER = 16'ha5a5;
   localparam int unsigned FLT_IMP = 0;
   localparam int unsigned FLT_ROC = 1;
   localparam int unsigned FLT_LINK = 2;
   localparam logic [31:0] HARD_MASK = 32'hff00_0000;
   localparam logic [31:0] FACT_MASK = 32'h0000_0000;
   localparam logic [31:0] FACT_ZMAX = 32'h0100_0000;
   localparam logic [31:0] FACT_ZMIN = 32'h0000_0000;
   localparam logic [31:0] FACT_RMAX = 32'h0000_0064;
   localparam logic [31:0] FACT_RMIN = 32'hffff_ff9c;
   localparam logic [31:0] FACT_TMO = 32'h0000_0000;
   localparam logic [31:0] FACT_REC = 32'h0000_0000;
   localparam logic [31:0] FACT_COEF = 32'h0000_0000;
   localparam int unsigned NV_WORDS = 12;
   localparam int unsigned FRAC = 15;

   // writable register image kept in nonvolatile memory
   typedef struct packed {
      logic [31:0] trip_mask;
      logic [31:0] z_max;
      logic [31:0] z_min;
      logic [31:0] rate_max;
      logic [31:0] rate_min;
      logic [31:0] timeout_period;
      logic [31:0] recorder_interval;
      logic [4:0][31:0] coef;
   } wregs_t;

   typedef struct packed {
      logic [15:0] header;
      logic [23:0] stamp;
      logic [15:0] command_word;
      logic [7:0] status;
      logic [7:0] module_count;
      logic [13:0][31:0] words;
   } rec_entry_t;

   typedef enum logic [3:0] {
      ST_BOOT = 4'b0001,
      ST_IDLE = 4'b0010,
      ST_LOAD = 4'b0100,
      ST_STORE = 4'b1000
   } nv_st_t;

   function automatic wregs_t factory_image();
      wregs_t w;
      w.trip_mask = FACT_MASK;
      w.z_max = FACT_ZMAX;
      w.z_min = FACT_ZMIN;
      w.rate_max = FACT_RMAX;
      w.rate_min = FACT_RMIN;
      w.timeout_period = FACT_TMO;
      w.recorder_interval = FACT_REC;
      w.coef = {5{FACT_COEF}};
      return w;
   endfunction

   function automatic logic signed [31:0] sat_q(input logic signed [63:0] v);
      if (v > 64'sd32768) begin
         return 32'sd32768;
      end else if (v < 64'sd0) begin
         return 32'sd0;
      end
      return v[31:0];
   endfunction
endpackage

//--- rtl/nv_image_mem.sv
// nonvolatile default image store with registered read data
`timescale 1ns/1ps
module nv_image_mem #(
   parameter int unsigned DEPTH = 12
) (
   // clock
   input wire logic clk_i,
   // access
   input wire logic wr_en_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o
);
   logic [31:0] mem_ff [DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_ff[addr_i] <= wdata_i;
      end
      rdata_o <= mem_ff[addr_i];
   end
endmodule

//--- verif/supv_checker.sv
// port-level assertions for the supervisory controller
`timescale 1ns/1ps
module supv_checker
   import supv_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // watched inputs
   input wire logic cmd_wr_i,
   input wire logic [15:0] cmd_code_i,
   input wire logic imp_mon_en_i,
   input wire logic link_tmo_en_i,
   input wire logic link_activity_i,
   input wire logic fault_reset_i,
   input wire logic warning_i,
   input wire logic [31:0] z_rate_i,
   input wire logic [31:0] ext_faults_i,
   input wire logic [23:0] rtc_i,
   // watched outputs
   input wire logic ready_o,
   input wire logic [15:0] cmd_readback_o,
   input wire wregs_t regs_o,
   input wire logic [31:0] fault_bits_o,
   input wire logic shutdown_o,
   input wire logic fault_reset_clr_o,
   input wire logic record_o,
   input wire rec_entry_t record_entry_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // silent cycles; 4 spare for the pipeline
   logic [31:0] quiet_ff;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || link_activity_i || !link_tmo_en_i) begin
         quiet_ff <= 32'h0000_0000;
      end else begin
         quiet_ff <= quiet_ff + 32'h0000_0001;
      end
   end
   sequence store_go;
      ready_o && cmd_wr_i && cmd_code_i == CMD_STORE;
   endsequence
   sequence restore_go;
      ready_o && cmd_wr_i && cmd_code_i == CMD_RESTORE;
   endsequence
   sequence factory_go;
      ready_o && cmd_wr_i && cmd_code_i == CMD_FACTORY;
   endsequence
   chk_store_done:
   assert property (store_go |=> cmd_readback_o == CMD_BUSY
      ##[1:40] cmd_readback_o == CMD_DONE)
      else $error("store did not complete");
   chk_restore_done:
   assert property (restore_go |=> cmd_readback_o == CMD_BUSY
      ##[1:60] cmd_readback_o == CMD_DONE)
      else $error("restore did not complete");
   chk_factory_image:
   assert property (factory_go |-> ##[1:4] (cmd_readback_o == CMD_DONE
      && regs_o.trip_mask == FACT_MASK && regs_o.z_max == FACT_ZMAX
      && regs_o.timeout_period == FACT_TMO))
      else $error("factory values not loaded");
   chk_imp_cause:
   assert property ($rose(fault_bits_o[FLT_IMP]) |->
      $past(imp_mon_en_i || ext_faults_i[FLT_IMP]))
      else $error("impedance fault without cause");
   chk_rate_window:
   assert property (imp_mon_en_i && ($signed(z_rate_i) >
      $signed(regs_o.rate_max) || $signed(z_rate_i) <
      $signed(regs_o.rate_min)) |=> fault_bits_o[FLT_ROC])
      else $error("rate outside window not reported");
   chk_hard_trip:
   assert property (|(ext_faults_i & HARD_MASK) |=> shutdown_o)
      else $error("hard fault did not shut down");
   chk_mask_trip:
   assert property (|(fault_bits_o & regs_o.trip_mask)
      && $stable(regs_o.trip_mask) |-> shutdown_o)
      else $error("masked fault did not shut down");
   chk_trip_cause:
   assert property ($rose(shutdown_o) |->
      |(fault_bits_o & (regs_o.trip_mask | HARD_MASK)))
      else $error("shutdown without cause");
   chk_reset_pulse:
   assert property ($rose(fault_reset_i) |->
      ##[1:2] fault_reset_clr_o ##1 !fault_reset_clr_o)
      else $error("fault reset did not self-clear");
   chk_link_silence:
   assert property (link_tmo_en_i && regs_o.timeout_period != 0 &&
      quiet_ff >= regs_o.timeout_period + 32'h0000_0004 |->
      fault_bits_o[FLT_LINK])
      else $error("link silence not reported");
   chk_warn_record:
   assert property ($rose(warning_i) |-> ##[1:3] record_o)
      else $error("warning not recorded");
   chk_record_stamp:
   assert property (record_o && $stable(rtc_i) |->
      record_entry_o.stamp == rtc_i && record_entry_o.header == REC_HEADER)
      else $error("record stamp or header wrong");
endmodule

bind supply_supervisory_controller supv_checker chk (
   .clk_i, .sys_rst_i, .cmd_wr_i, .cmd_code_i, .imp_mon_en_i,
   .link_tmo_en_i, .link_activity_i, .fault_reset_i, .warning_i,
   .z_rate_i, .ext_faults_i, .rtc_i, .ready_o, .cmd_readback_o,
   .regs_o, .fault_bits_o, .shutdown_o, .fault_reset_clr_o,
   .record_o, .record_entry_o
);

//--- verif/host_link_model.sv
// host link model: image loads, default-store commands, keepalive
`timescale 1ns/1ps
module host_link_model
   import supv_pkg::*;
(
   // clock and control
   input wire logic clk_i,
   input wire logic keepalive_i,
   // device answers
   input wire logic ready_i,
   input wire logic [15:0] readback_i,
   // link requests
   output logic wr_en_o,
   output wregs_t wr_data_o,
   output logic cmd_wr_o,
   output logic [15:0] cmd_code_o,
   output logic link_activity_o
);
   logic [3:0] gap_ff = 4'h0;
   initial begin
      {wr_en_o, wr_data_o, cmd_wr_o, cmd_code_o, link_activity_o} = '0;
   end
   // a pulse every 16 cycles, well inside the timeout
   always @(negedge clk_i) begin
      gap_ff <= gap_ff + 4'h1;
      link_activity_o <= keepalive_i && gap_ff == 4'h0;
   end
   task automatic wait_ready();
      while (ready_i !== 1'b1) @(negedge clk_i);
   endtask
   // coefficients travel in the image
   task automatic load_image(input wregs_t w);
      @(negedge clk_i);
      wait_ready();
      wr_data_o = w;
      wr_en_o = 1'b1;
      @(negedge clk_i);
      wr_en_o = 1'b0;
      wr_data_o = ~w;
   endtask
   // nothing goes out until ready is seen
   task automatic send_cmd(input logic [15:0] code,
                           output logic [15:0] pend, output logic done);
      int n;
      @(negedge clk_i);
      wait_ready();
      cmd_code_o = code;
      cmd_wr_o = 1'b1;
      @(negedge clk_i);
      cmd_wr_o = 1'b0;
      cmd_code_o = ~code;
      pend = readback_i;
      done = 1'b0;
      for (n = 0; n < 200 && !done; n++) begin
         @(negedge clk_i);
         done = (readback_i === CMD_DONE);
      end
   endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the supply supervisory controller
`timescale 1ns/1ps
module testbench
   import supv_pkg::*;
();
   localparam int unsigned TB_DIV = 100;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic wr_en_i, cmd_wr_i, link_activity_i, keepalive, done;
   wregs_t wr_data_i, regs_o, w, fw;
   logic [15:0] cmd_code_i, cmd_readback_o, pend;
   logic imp_mon_en_i, link_tmo_en_i, recorder_enable_i, fault_reset_i;
   logic digital_prog_i, process_mode_i, proc_sp_analog_i, warning_i;
   logic proc_drive_current_i, proc_analog_cap_i;
   logic [31:0] v_meas_i, i_meas_i, z_rate_i, ext_faults_i, v_prog_i;
   logic [31:0] i_prog_i, p_prog_i, v_setpoint_i, i_setpoint_i, p_setpoint_i;
   logic [31:0] fault_bits_o, v_cmd_o, i_cmd_o;
   logic [23:0] rtc_i;
   logic [7:0] module_count_i;
   logic shutdown_o, fault_reset_clr_o, ready_o, record_o, save_request_o;
   rec_entry_t record_entry_o;
   int miscompares = 0;
   int n_checks = 0;
   always #5 clk_i = ~clk_i;
   // short loop divider
   supply_supervisory_controller #(.DIV(TB_DIV)) uut (
      .clk_i, .sys_rst_i, .wr_en_i, .wr_data_i, .cmd_wr_i, .cmd_code_i,
      .link_activity_i, .imp_mon_en_i, .link_tmo_en_i, .recorder_enable_i,
      .fault_reset_i, .digital_prog_i, .process_mode_i, .proc_sp_analog_i,
      .proc_drive_current_i, .proc_analog_cap_i, .v_meas_i, .i_meas_i,
      .z_rate_i, .ext_faults_i, .warning_i, .v_prog_i, .i_prog_i, .p_prog_i,
      .v_setpoint_i, .i_setpoint_i, .p_setpoint_i, .rtc_i, .module_count_i,
      .cmd_readback_o, .regs_o, .fault_bits_o, .shutdown_o,
      .fault_reset_clr_o, .ready_o, .record_o, .record_entry_o,
      .save_request_o, .v_cmd_o, .i_cmd_o
   );
   host_link_model host (
      .clk_i, .keepalive_i(keepalive), .ready_i(ready_o),
      .readback_i(cmd_readback_o), .wr_en_o(wr_en_i), .wr_data_o(wr_data_i),
      .cmd_wr_o(cmd_wr_i), .cmd_code_o(cmd_code_i),
      .link_activity_o(link_activity_i)
   );
   task automatic check(input logic [383:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wait_pulse(ref logic s, input int lim);
      int k;
      for (k = 0; k < lim && s !== 1'b1; k++) cyc(1);
      check(s, 1'b1);
   endtask
   task automatic boot();
      int k;
      sys_rst_i = 1'b1;
      cyc(4);
      sys_rst_i = 1'b0;
      for (k = 0; k < 100 && ready_o !== 1'b1; k++) cyc(1);
      check({ready_o, cmd_readback_o}, {1'b1, CMD_DONE});
   endtask
   task automatic cmd(input logic [15:0] code);
      host.send_cmd(code, pend, done);
      check(done, 1'b1);
      if (code != CMD_FACTORY) begin
         check(pend, CMD_BUSY);
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      $display("ERROR at %0t: watchdog expired", $time);
      miscompares++;
      stop_test();
   end
   initial begin
      {imp_mon_en_i, link_tmo_en_i, recorder_enable_i, fault_reset_i,
       digital_prog_i, process_mode_i, proc_sp_analog_i, warning_i,
       proc_drive_current_i, proc_analog_cap_i, keepalive} = '0;
      {v_meas_i, i_meas_i, z_rate_i, ext_faults_i, v_prog_i, i_prog_i,
       p_prog_i, v_setpoint_i, i_setpoint_i, p_setpoint_i} = '0;
      rtc_i = 24'h5a_1234;
      module_count_i = 8'h06;
      w = '0;
      w.trip_mask = 32'h0000_0001;
      w.z_max = 32'h0100_0000;
      w.z_min = 32'h0080_0000;
      w.rate_max = 32'h0000_0064;
      w.rate_min = 32'hffff_ff9c;
      w.timeout_period = 32'h0000_0032;
      w.recorder_interval = 32'h0000_0002;
      w.coef[0] = 32'h0000_8000;
      fw = {FACT_MASK, FACT_ZMAX, FACT_ZMIN, FACT_RMAX, FACT_RMIN, FACT_TMO,
            FACT_REC, {5{FACT_COEF}}};
      boot();
      host.load_image(w);
      cmd(CMD_STORE);
      host.load_image(fw);
      cmd(CMD_RESTORE);
      check(regs_o, w);
      cmd(CMD_FACTORY);
      check(regs_o, fw);
      cmd(CMD_RESTORE);
      // 0.75 inside the window, rate trips report only
      i_meas_i = 32'h0000_4000;
      v_meas_i = 32'h0000_3000;
      imp_mon_en_i = 1'b1;
      cyc(4);
      check(fault_bits_o, 32'h0000_0000);
      z_rate_i = 32'h0000_00c8;
      cyc(3);
      check({shutdown_o, fault_bits_o}, {1'b0, 32'h0000_0002});
      z_rate_i = 32'h0000_0000;
      fault_reset_i = 1'b1;
      cyc(3);
      check(fault_bits_o, 32'h0000_0000);
      fault_reset_i = 1'b0;
      z_rate_i = 32'hffff_ff38;
      cyc(3);
      check(fault_bits_o, 32'h0000_0002);
      z_rate_i = 32'h0000_0000;
      imp_mon_en_i = 1'b0;
      v_meas_i = 32'h0000_8000;
      cyc(3);
      check(fault_bits_o[0], 1'b0);
      imp_mon_en_i = 1'b1;
      cyc(3);
      check({shutdown_o, fault_bits_o[0]}, 2'b11);
      imp_mon_en_i = 1'b0;
      boot();
      check(regs_o, w);
      keepalive = 1'b1;
      link_tmo_en_i = 1'b1;
      cyc(150);
      keepalive = 1'b0;
      cyc(30);
      check(fault_bits_o[2], 1'b0);
      cyc(30);
      check({shutdown_o, fault_bits_o[2]}, 2'b01);
      link_tmo_en_i = 1'b0;
      ext_faults_i = 32'h0100_0000;
      cyc(3);
      check({shutdown_o, fault_bits_o[24]}, 2'b11);
      ext_faults_i = 32'h0000_0000;
      recorder_enable_i = 1'b1;
      wait_pulse(save_request_o, 300);
      wait_pulse(record_o, 300);
      check({record_entry_o.header, record_entry_o.stamp,
             record_entry_o.module_count},
            {REC_HEADER, rtc_i, module_count_i});
      cyc(2);
      warning_i = 1'b1;
      wait_pulse(record_o, 5);
      boot();
      // unit gain: command is setpoint minus feedback
      process_mode_i = 1'b1;
      digital_prog_i = 1'b1;
      p_setpoint_i = 32'h0000_4000;
      p_prog_i = 32'h0000_1000;
      v_setpoint_i = 32'h0000_8000;
      i_setpoint_i = 32'h0000_8000;
      cyc(2 * TB_DIV + 10);
      check(v_cmd_o, 32'h0000_3000);
      proc_sp_analog_i = 1'b1;
      v_prog_i = 32'h0000_2000;
      cyc(2 * TB_DIV + 10);
      check(v_cmd_o, 32'h0000_1000);
      v_setpoint_i = 32'h0000_0800;
      cyc(2 * TB_DIV + 10);
      check(v_cmd_o, 32'h0000_0800);
      proc_drive_current_i = 1'b1;
      cyc(2 * TB_DIV + 10);
      check(i_cmd_o, 32'h0000_1000);
      digital_prog_i = 1'b0;
      proc_analog_cap_i = 1'b1;
      i_prog_i = 32'h0000_0400;
      cyc(2 * TB_DIV + 10);
      check(i_cmd_o, 32'h0000_0400);
      process_mode_i = 1'b0;
      cyc(2);
      check({v_cmd_o, i_cmd_o}, {v_prog_i, i_prog_i});
      stop_test();
   end
endmodule
